/* File: src/display_channel_legacy_tx_mode_detect.sv */
// legacy sync-clocked edid transmitter with host mode detection
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module display_channel_legacy_tx_mode_detect #(
  parameter int SYNC_CLOCKS = ddc_pkg::SYNC_CLOCKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // host link pins
  input wire logic vsync_pin,
  input wire logic host_clock_line_pin,
  output logic data_line_out,
  output logic data_line_oe_n,
  // interrupt
  output logic irq
);
  import ddc_pkg::*;

  // synchronised pins and edge history
  logic [1:0] pins_sync; // {vsync, host clock line}
  logic vsync_s; // vsync after two flops
  logic scl_s; // host clock line after two flops
  logic vsync_prev; // last synchronised vsync
  logic scl_prev; // last synchronised clock line
  logic vs_rise; // one bit period starts
  logic scl_fall; // host announces the newer protocol

  // channel control fields
  logic edid_size_select;
  logic software_feed_enable;
  logic byte_feed_irq_flag;
  logic legacy_tx_enable;
  logic mode_switch_irq_flag;
  logic channel_mode_flag; // 0 legacy, 1 newer protocol

  // other registers
  logic [7:0] legacy_tx_byte; // hold register of the transmitter
  logic [7:0] edid_pointer; // post-incrementing buffer address
  logic [7:0] irq_mask; // same layout as the flag bits

  // bus phase tracking
  logic ph_valid; // a data phase is in progress
  logic ph_write; // that data phase is a write
  logic [7:0] ph_index; // register index of that data phase
  logic rd_wait; // second cycle of a read data phase
  logic addr_accept; // address phase taken this edge
  logic [7:0] addr_index;
  logic wr_now; // write data phase, zero wait
  logic rd_first; // first read data cycle, wait state
  logic [7:0] control_rd; // control register as read back

  // buffer port and pointer
  logic sw_buf_write;
  logic sw_buf_read_inc;
  logic hw_issue; // hardware fetch owns the memory port
  logic ptr_inc;
  logic [7:0] ptr_limit;
  logic [7:0] next_pointer;
  logic [7:0] ram_rdata;
  logic fetch_req; // hold register wants a byte from the buffer
  logic fetch_cap; // buffer byte arrives this cycle

  // transmitter
  tx_state_t state;
  logic [3:0] sync_cnt; // sync clocks seen during startup
  logic [2:0] bit_cnt; // bit of the byte on the line
  logic [7:0] shift; // msb drives the data line
  logic active; // legacy mode enabled and not switched
  logic start_event;
  logic gap_event; // ninth bit period begins

  // write strobes
  logic wr_tx_byte;
  logic wr_pointer;
  logic wr_control;
  logic wr_mask;
  logic clr_byte_flag;
  logic clr_switch_flag;

  // pins pass two flops before anything looks at them
  bit_sync #(.W(2)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .d({vsync_pin, host_clock_line_pin}),
    .q(pins_sync)
  );

  assign vsync_s = pins_sync[1];
  assign scl_s = pins_sync[0];

  // edge history; reset at zero so a line idling high gives no false fall
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vsync_prev <= 1'b0;
      scl_prev <= 1'b0;
    end else begin
      vsync_prev <= vsync_s;
      scl_prev <= scl_s;
    end
  end

  assign vs_rise = vsync_s & ~vsync_prev;
  assign scl_fall = ~scl_s & scl_prev;

  // bus decode: reads take one wait state so buffer data can be registered
  assign addr_accept = hsel & hready & htrans[1];
  assign addr_index = haddr[9:2];
  assign wr_now = ph_valid & ph_write;
  assign rd_first = ph_valid & ~ph_write & ~rd_wait;
  assign hreadyout = ~rd_first;
  assign hresp = HRESP_OKAY;

  // data phase bookkeeping, held while the bus is stalled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_index <= 8'h00;
    end else if (hready) begin
      ph_valid <= addr_accept;
      ph_write <= hwrite;
      ph_index <= addr_index;
    end
  end

  // wait state marker
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= rd_first;
    end
  end

  // write strobes land in the write data phase
  assign wr_tx_byte = wr_now & (ph_index == IDX_TX_BYTE);
  assign wr_pointer = wr_now & (ph_index == IDX_POINTER);
  assign wr_control = wr_now & (ph_index == IDX_CONTROL);
  assign wr_mask = wr_now & (ph_index == IDX_IRQ_MASK);
  assign clr_byte_flag = wr_control & hwdata[BIT_BYTE_IRQ];
  assign clr_switch_flag = wr_control & hwdata[BIT_SWITCH_IRQ];

  // memory port: the pointer is always the address, so every access moves it
  assign sw_buf_write = wr_now & (ph_index == IDX_BUFFER);
  assign sw_buf_read_inc = rd_first & (ph_index == IDX_BUFFER);
  // hardware waits for an idle bus; back-to-back traffic can delay it
  assign hw_issue = fetch_req & ~addr_accept & ~ph_valid;
  assign ptr_inc = sw_buf_write | sw_buf_read_inc | hw_issue;

  assign ptr_limit = edid_size_select ? LIMIT_LARGE : LIMIT_SMALL;
  assign next_pointer = (edid_pointer == ptr_limit) ? WRAP_ADDR :
                        edid_pointer + 8'h01;

  edid_ram #(.AW(8), .DW(8)) u_buffer (
    .clk(clk),
    .resetn(resetn),
    .we(sw_buf_write),
    .addr(edid_pointer),
    .wdata(hwdata[7:0]),
    .rdata(ram_rdata)
  );

  // pointer: software loads it, every buffer access bumps it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      edid_pointer <= RST_POINTER;
    end else if (wr_pointer) begin
      edid_pointer <= hwdata[7:0];
    end else if (ptr_inc) begin
      edid_pointer <= next_pointer;
    end
  end

  // control fields that software owns
  always_ff @(posedge clk) begin
    if (!resetn) begin
      edid_size_select <= 1'b0;
      software_feed_enable <= 1'b0;
      legacy_tx_enable <= 1'b0;
    end else if (wr_control) begin
      edid_size_select <= hwdata[BIT_SIZE];
      software_feed_enable <= hwdata[BIT_SWFEED];
      legacy_tx_enable <= hwdata[BIT_ENABLE];
    end
  end

  // interrupt mask, only the two flag positions exist
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask <= 8'h00;
      irq_mask[BIT_BYTE_IRQ] <= hwdata[BIT_BYTE_IRQ];
      irq_mask[BIT_SWITCH_IRQ] <= hwdata[BIT_SWITCH_IRQ];
    end
  end

  // mode flag: cleared only by reset, which stands for power-on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channel_mode_flag <= 1'b0;
    end else if (scl_fall) begin
      channel_mode_flag <= 1'b1;
    end
  end

  // switch flag: a fall in the clearing cycle still sets it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_switch_irq_flag <= 1'b0;
    end else if (scl_fall & ~channel_mode_flag) begin
      mode_switch_irq_flag <= 1'b1;
    end else if (clr_switch_flag) begin
      mode_switch_irq_flag <= 1'b0;
    end
  end

  // transmitter events; the newer protocol always wins
  assign active = legacy_tx_enable & ~channel_mode_flag;
  assign start_event = active & vs_rise & (state == ST_IDLE);
  assign gap_event = active & vs_rise & (state == ST_SHIFT) &
                     (bit_cnt == LAST_BIT);

  // byte flag: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_feed_irq_flag <= 1'b0;
    end else if (gap_event & software_feed_enable) begin
      byte_feed_irq_flag <= 1'b1;
    end else if (clr_byte_flag) begin
      byte_feed_irq_flag <= 1'b0;
    end
  end

  // hardware feed: ask for a byte at start-up and at each ninth bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fetch_req <= 1'b0;
    end else if ((start_event | gap_event) & ~software_feed_enable) begin
      fetch_req <= 1'b1;
    end else if (hw_issue) begin
      fetch_req <= 1'b0;
    end
  end

  // fetched byte comes out of the memory register a cycle later
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fetch_cap <= 1'b0;
    end else begin
      fetch_cap <= hw_issue;
    end
  end

  // hold register; a software write beats a colliding fetch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      legacy_tx_byte <= RST_TX_BYTE;
    end else if (wr_tx_byte) begin
      legacy_tx_byte <= hwdata[7:0];
    end else if (fetch_cap) begin
      legacy_tx_byte <= ram_rdata;
    end
  end

  // transmitter walks on vsync rising edges; the line is never sampled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      sync_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      data_line_oe_n <= 1'b1;
    end else if (!active) begin
      state <= ST_IDLE;
      data_line_oe_n <= 1'b1;
    end else if (vs_rise) begin
      case (state)
        ST_IDLE: begin
          state <= ST_SYNC;
          sync_cnt <= 4'h0;
          data_line_oe_n <= 1'b1;
        end
        ST_SYNC: begin
          // line stays released for the whole startup
          if (sync_cnt == 4'(SYNC_CLOCKS - 1)) begin
            state <= ST_SHIFT;
            shift <= legacy_tx_byte;
            bit_cnt <= 3'h0;
            data_line_oe_n <= 1'b0;
          end else begin
            sync_cnt <= sync_cnt + 4'h1;
          end
        end
        ST_SHIFT: begin
          if (bit_cnt == LAST_BIT) begin
            state <= ST_GAP;
            data_line_oe_n <= 1'b1;
          end else begin
            shift <= {shift[6:0], 1'b0};
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        ST_GAP: begin
          // software had this whole period to refill the hold byte
          state <= ST_SHIFT;
          shift <= legacy_tx_byte;
          bit_cnt <= 3'h0;
          data_line_oe_n <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          data_line_oe_n <= 1'b1;
        end
      endcase
    end
  end

  assign data_line_out = shift[7];

  // read data register, loaded in the wait state
  assign control_rd = {1'b0, edid_size_select, software_feed_enable, 1'b0,
                       byte_feed_irq_flag, legacy_tx_enable,
                       mode_switch_irq_flag, channel_mode_flag};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_first) begin
      case (ph_index)
        IDX_TX_BYTE: hrdata <= {24'h00_0000, legacy_tx_byte};
        IDX_POINTER: hrdata <= {24'h00_0000, edid_pointer};
        IDX_CONTROL: hrdata <= {24'h00_0000, control_rd};
        IDX_BUFFER: hrdata <= {24'h00_0000, ram_rdata};
        IDX_IRQ_MASK: hrdata <= {24'h00_0000, irq_mask};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // one level interrupt for both flags
  assign irq = (byte_feed_irq_flag & irq_mask[BIT_BYTE_IRQ]) |
               (mode_switch_irq_flag & irq_mask[BIT_SWITCH_IRQ]);

  property p_switch_time;
    @(posedge clk) disable iff (!resetn)
    ($fell(host_clock_line_pin) && !channel_mode_flag) |->
      ##[1:3] channel_mode_flag;
  endproperty
  a_switch_time: assert property (p_switch_time)
    else $error("mode switch slower than three clocks");

  property p_mode_sticky;
    @(posedge clk) disable iff (!resetn)
    channel_mode_flag |=> channel_mode_flag;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky)
    else $error("mode flag left the switched state");

  property p_switch_flag;
    @(posedge clk) disable iff (!resetn)
    $rose(channel_mode_flag) |-> mode_switch_irq_flag;
  endproperty
  a_switch_flag: assert property (p_switch_flag)
    else $error("switch flag not set with mode change");

  property p_disabled_quiet;
    @(posedge clk) disable iff (!resetn)
    (!legacy_tx_enable) [*2] |-> data_line_oe_n && (state == ST_IDLE);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("transmitter active while disabled");

  property p_byte_flag_cause;
    @(posedge clk) disable iff (!resetn)
    $rose(byte_feed_irq_flag) |->
      $past(software_feed_enable) && !$past(channel_mode_flag);
  endproperty
  a_byte_flag_cause: assert property (p_byte_flag_cause)
    else $error("byte flag set outside software feed");

  property p_ninth_irq;
    @(posedge clk) disable iff (!resetn)
    (gap_event && software_feed_enable) |=>
      byte_feed_irq_flag && (state == ST_GAP);
  endproperty
  a_ninth_irq: assert property (p_ninth_irq)
    else $error("no byte interrupt at ninth bit");

  property p_wrap;
    @(posedge clk) disable iff (!resetn)
    (ptr_inc && !wr_pointer && (edid_pointer == ptr_limit)) |=>
      (edid_pointer == WRAP_ADDR);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap at the limit");

  property p_increment;
    @(posedge clk) disable iff (!resetn)
    (ptr_inc && !wr_pointer && (edid_pointer != ptr_limit)) |=>
      (edid_pointer == $past(edid_pointer) + 8'h01);
  endproperty
  a_increment: assert property (p_increment)
    else $error("pointer did not step by one");

  property p_sync_released;
    @(posedge clk) disable iff (!resetn)
    (state == ST_SYNC) || (state == ST_GAP) |-> data_line_oe_n;
  endproperty
  a_sync_released: assert property (p_sync_released)
    else $error("data line driven during startup or ninth bit");

endmodule

/* File: common/ddc_pkg.sv */
// constants and types shared by the display channel legacy transmitter
// Operation
// - size select picks 256 or 128 byte region
// - pointer wraps to zero past upper limit
// - software feed raises interrupt in ninth bit
// - hardware feed reloads hold byte from buffer
// - byte flag set only legacy software feed
// - enable clear ignores sync and stops transmit
// - clock line fall sets mode switch flag
// - mode flag resets legacy, sticks once switched
// - readable writable eight bit transmit byte register
// - pointer increments after every buffer port access
// - transmit starts on first sync when enabled
// - switch completes within three system clocks
// - sync pulse clocks one bit out
// - nine sync clocks startup, line released
// - legacy mode only transmits, never receives
package ddc_pkg;

  // system clock period
  localparam int CLK_PERIOD_NS = 40;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_TX_BYTE = 8'hd5;
  localparam logic [7:0] IDX_POINTER = 8'hd6;
  localparam logic [7:0] IDX_CONTROL = 8'hd7;
  localparam logic [7:0] IDX_BUFFER = 8'hd8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd9;

  // channel control field positions
  localparam int BIT_SIZE = 6;
  localparam int BIT_SWFEED = 5;
  localparam int BIT_BYTE_IRQ = 3;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_SWITCH_IRQ = 1;
  localparam int BIT_MODE = 0;

  // reset values
  localparam logic [7:0] RST_TX_BYTE = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // pointer limits for the two region sizes
  localparam logic [7:0] LIMIT_SMALL = 8'h7f;
  localparam logic [7:0] LIMIT_LARGE = 8'hff;
  localparam logic [7:0] WRAP_ADDR = 8'h00;

  // link framing
  localparam int SYNC_CLOCKS = 9;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // timing figures
  localparam int MODE_SWITCH_MAX_CLK = 3;
  localparam int FEED_DEADLINE_US = 40;
  localparam int FEED_DEADLINE_CLK = FEED_DEADLINE_US * 1000 / CLK_PERIOD_NS;

  // bus answer
  localparam logic HRESP_OKAY = 1'b0;

  // transmitter states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_SHIFT = 4'h4,
    ST_GAP = 4'h8
  } tx_state_t;

endpackage

/* File: src/bit_sync.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1; // first stage, read only by q

  // both stages run every edge; only q is seen by logic
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

/* File: src/edid_ram.sv */
// single port buffer memory with registered read data
`timescale 1ns/1ns
module edid_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // one port, address shared by read and write
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1]; // contents are not reset

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read data one cycle after the address, from a register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule

/* File: testbench/host_model.sv */
// host-side model: sync pulses as bit clock, clock line, data line sampling
`timescale 1ns/1ns
module host_model (
  // system clock, used only to time clock line changes
  input wire logic clk,
  // link pins
  output logic vsync_pin,
  output logic host_clock_line_pin,
  input wire logic data_line_out,
  input wire logic data_line_oe_n
);
  // {released, level} seen just before each sync rise of the last burst
  logic [1:0] seen [0:31];
  // wire level: released line floats up through the pull-up
  logic line;

  assign line = data_line_oe_n ? 1'b1 : data_line_out;

  // both lines idle high/low, sync stands still between bursts
  initial begin
    vsync_pin = 1'b0;
    host_clock_line_pin = 1'b1;
  end

  // burst of n sync pulses, 320 ns period, phase unrelated to clk
  task automatic send_pulses(input int n);
    #7;
    for (int k = 0; k < n; k++) begin
      #159;
      // only observed, never driven: the host just listens
      seen[k] = {data_line_oe_n, line};
      #1 vsync_pin = 1'b1;
      #160 vsync_pin = 1'b0;
    end
  endtask

  // first high-to-low on the clock line announces a newer host
  task automatic pull_clock_line();
    @(posedge clk);
    host_clock_line_pin <= 1'b0;
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the legacy edid transmitter
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; \
  if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import ddc_pkg::*;
  // byte addresses, four times the register index
  localparam logic [31:0] A_TX = {22'h0, IDX_TX_BYTE, 2'b00};
  localparam logic [31:0] A_PTR = {22'h0, IDX_POINTER, 2'b00};
  localparam logic [31:0] A_CTL = {22'h0, IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_BUF = {22'h0, IDX_BUFFER, 2'b00};
  localparam logic [31:0] A_MSK = {22'h0, IDX_IRQ_MASK, 2'b00};
  // generous ceiling, the run needs under a thousand cycles
  localparam int LIMIT = 20000;

  logic clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic vsync_pin, host_clock_line_pin, data_line_out, data_line_oe_n;
  int n_errors, num_checks, cycles;

  display_channel_legacy_tx_mode_detect
    i_display_channel_legacy_tx_mode_detect (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .vsync_pin(vsync_pin),
    .host_clock_line_pin(host_clock_line_pin),
    .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
    .irq(irq));

  host_model i_host_model (
    .clk(clk), .vsync_pin(vsync_pin),
    .host_clock_line_pin(host_clock_line_pin),
    .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n));

  // system clock, 40 ns period
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  // ready is judged at the falling edge, where it is settled
  task automatic wait_ready();
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  // single word write: address phase, then data phase
  task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b1;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask

  // single word read, data taken at the falling edge before the edge that ends the data phase
  task automatic bus_rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'b00;
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    d = hrdata[7:0];
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_rd(a, d);
    `CHK("register", e, d)
  endtask

  // released for n samples starting at first
  task automatic chk_idle(input int first, input int n);
    for (int i = first; i < first + n; i++)
      `CHK("idle", 2'b11, i_host_model.seen[i])
  endtask

  // one byte on the wire, msb first, driven
  task automatic chk_byte(input int first, input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      `CHK("bit", {1'b0, v[7-i]}, i_host_model.seen[first+i])
  endtask

  task automatic t_reset();
    rd_chk(A_TX, RST_TX_BYTE);
    rd_chk(A_PTR, RST_POINTER);
    rd_chk(A_CTL, 8'h00);
    rd_chk(A_MSK, RST_IRQ_MASK);
    `CHK("irq", 1'b0, irq)
    `CHK("hresp", HRESP_OKAY, hresp)
    bus_wr(A_TX, 8'hc3);
    rd_chk(A_TX, 8'hc3);
    // a transfer without select must leave the register alone
    hsel <= 1'b0;
    bus_wr(A_TX, 8'h77);
    hsel <= 1'b1;
    rd_chk(A_TX, 8'hc3);
    bus_wr(32'h0000_0000, 8'h5a);
    rd_chk(32'h0000_0000, 8'h00);
  endtask

  task automatic t_pointer();
    bus_wr(A_PTR, 8'h7e);
    bus_wr(A_BUF, 8'h11);
    bus_wr(A_BUF, 8'h22);
    rd_chk(A_PTR, WRAP_ADDR);
    bus_wr(A_PTR, 8'h7e);
    rd_chk(A_BUF, 8'h11);
    rd_chk(A_PTR, 8'h7f);
    bus_wr(A_CTL, 8'h40);
    bus_wr(A_BUF, 8'h33);
    rd_chk(A_PTR, 8'h80);
    bus_wr(A_PTR, LIMIT_LARGE);
    bus_wr(A_BUF, 8'h44);
    rd_chk(A_PTR, WRAP_ADDR);
    bus_wr(A_CTL, 8'h00);
  endtask

  task automatic t_disabled();
    i_host_model.send_pulses(12);
    chk_idle(0, 12);
  endtask

  task automatic t_hw_feed();
    bus_wr(A_PTR, 8'h00);
    bus_wr(A_BUF, 8'ha5);
    bus_wr(A_BUF, 8'h3c);
    bus_wr(A_PTR, 8'h00);
    bus_wr(A_CTL, 8'h04);
    i_host_model.send_pulses(27);
    chk_idle(0, 10);
    chk_byte(10, 8'ha5);
    chk_idle(18, 1);
    chk_byte(19, 8'h3c);
    rd_chk(A_CTL, 8'h04);
    // the last sync opens the second ninth bit, which fetches a third byte
    rd_chk(A_PTR, 8'h03);
    bus_wr(A_CTL, 8'h00);
  endtask

  task automatic t_sw_feed();
    bus_wr(A_TX, 8'h96);
    bus_wr(A_MSK, 8'h08);
    bus_wr(A_CTL, 8'h24);
    i_host_model.send_pulses(18);
    chk_byte(10, 8'h96);
    rd_chk(A_CTL, 8'h2c);
    `CHK("irq", 1'b1, irq)
    bus_wr(A_MSK, 8'h00);
    // let the mask written at this edge settle before looking
    #1;
    `CHK("irq", 1'b0, irq)
    bus_wr(A_MSK, 8'h08);
    // the next byte comes from anywhere, well inside the deadline
    bus_wr(A_TX, 8'h5a);
    bus_wr(A_CTL, 8'h2c);
    rd_chk(A_CTL, 8'h24);
    `CHK("irq", 1'b0, irq)
    i_host_model.send_pulses(9);
    chk_byte(1, 8'h5a);
    // that byte ended too, so the flag is pending again; clear it
    rd_chk(A_CTL, 8'h2c);
    bus_wr(A_CTL, 8'h08);
    rd_chk(A_CTL, 8'h00);
  endtask

  task automatic t_switch();
    bus_wr(A_MSK, 8'h02);
    bus_wr(A_CTL, 8'h04);
    i_host_model.pull_clock_line();
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    rd_chk(A_CTL, 8'h07);
    i_host_model.send_pulses(12);
    chk_idle(0, 12);
    bus_wr(A_CTL, 8'h06);
    rd_chk(A_CTL, 8'h05);
    `CHK("irq", 1'b0, irq)
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset for 20 cycles, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_pointer();
    t_disabled();
    t_hw_feed();
    t_sw_feed();
    t_switch();
    stop_test();
  end
endmodule
